// ==== design/dcmx_cfg.svh ====
// dcmx constants: register map, field positions, reset values, widths
`ifndef DCMX_CFG_SVH
`define DCMX_CFG_SVH

`define DCMX_LANES      4
`define DCMX_FW         48

// address fields
`define DCMX_F_LANE     5:4
`define DCMX_F_REG      3:2
`define DCMX_F_GLB      7:6
`define DCMX_GLB_LANES  2'h0

// per-lane register index, lane base = lane * 0x10
`define DCMX_R_CTRL     2'h0
`define DCMX_R_FRQL     2'h1
`define DCMX_R_FRQH     2'h2
`define DCMX_R_DCV      2'h3

// global registers
`define DCMX_A_SUM      8'h40
`define DCMX_A_STAT     8'h44

// lane control fields
`define DCMX_F_MODE     1:0
`define DCMX_F_CSH      3:2
`define DCMX_F_F8       5:4
`define DCMX_B_GAIN     6
`define DCMX_B_SRC      7

// reset values
`define DCMX_CTRL_RST   8'h00
`define DCMX_SUM_RST    8'hc3
`define DCMX_F_SUM_A    3:0
`define DCMX_F_SUM_B    7:4

// gain shift of the q1.15 product, boost clear and set
`define DCMX_SH_LOW     16
`define DCMX_SH_BOOST   15
`define DCMX_LUT_QTR    6'h10

`define DCMX_RESP_OK    2'b00
`define DCMX_RESP_ERR   2'b10

`endif

// ==== design/dcmx_pkg.sv ====
// dcmx package: shared types of the upconverter mixer
package dcmx_pkg;
  typedef logic signed [15:0] dcmx_samp_t;
  typedef logic [3:0][15:0]   dcmx_lanes_t;
  typedef logic [7:0]         dcmx_addr_t;
  typedef logic [31:0]        dcmx_word_t;
  typedef logic [3:0]         dcmx_strb_t;
  typedef logic [1:0]         dcmx_resp_t;
  typedef enum logic [1:0] {
    mode_coarse,
    mode_fs8,
    mode_nco
  } dcmx_mode_t;
  typedef enum logic [1:0] {
    csh_half,
    csh_qplus,
    csh_qminus
  } dcmx_csh_t;
endpackage

// ==== design/dcmx_top.sv ====
// dcmx_top: four-lane upconverter mixer, summer and axi4-lite registers
//
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "dcmx_cfg.svh"
////////////////////////////////////////////////////////////////////////
// What this block does
// - four independent mixers, one per lane
// - real output is i*cos minus q*sin
// - each channel sums two lanes by default
// - summer adds any lanes into either channel
// - lane input from link or constant
// - each lane owns oscillator and multiplier; one summer shared by all lanes
// - three oscillator modes per lane
// - coarse mode shifts by fs/2, +fs/4, -fs/4
// - coarse realised by negating and swapping i/q
// - gain boost ignored in coarse mode
// - eighth mode uses fixed constants, accumulator idle
// - eighth mode offers 1, 3, 5, 7 eighths
// - result scaled by two to gain minus one
// - 48-bit frequency word phase accumulator
// - phase offset added to top 16 bits
// - boost clear gives minus 6 db
// - boost set adds 6 db, may clip
// - accumulator updates once per sample clock in nco mode, holds otherwise
// - summer rounds one bit per added lane
module dcmx_top (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // link samples, one i/q pair per lane and clock
  input  wire dcmx_pkg::dcmx_lanes_t link_i,
  input  wire dcmx_pkg::dcmx_lanes_t link_q,
  // converter channel digital inputs
  output      dcmx_pkg::dcmx_samp_t  chan_a,
  output      dcmx_pkg::dcmx_samp_t  chan_b,
  // axi4-lite write address
  input  wire logic                  s_axi_awvalid,
  output      logic                  s_axi_awready,
  input  wire dcmx_pkg::dcmx_addr_t  s_axi_awaddr,
  // axi4-lite write data
  input  wire logic                  s_axi_wvalid,
  output      logic                  s_axi_wready,
  input  wire dcmx_pkg::dcmx_word_t  s_axi_wdata,
  input  wire dcmx_pkg::dcmx_strb_t  s_axi_wstrb,
  // axi4-lite write response
  output      logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output      dcmx_pkg::dcmx_resp_t  s_axi_bresp,
  // axi4-lite read address
  input  wire logic                  s_axi_arvalid,
  output      logic                  s_axi_arready,
  input  wire dcmx_pkg::dcmx_addr_t  s_axi_araddr,
  // axi4-lite read data
  output      logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output      dcmx_pkg::dcmx_word_t  s_axi_rdata,
  output      dcmx_pkg::dcmx_resp_t  s_axi_rresp
);
  import dcmx_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic is_lane(input dcmx_addr_t a);
    return a[`DCMX_F_GLB] == `DCMX_GLB_LANES;
  endfunction

  function automatic logic addr_ok(input dcmx_addr_t a);
    return is_lane(a) || a == `DCMX_A_SUM || a == `DCMX_A_STAT;
  endfunction

  function automatic dcmx_word_t merge(input dcmx_word_t o,
                                       input dcmx_word_t n,
                                       input dcmx_strb_t s);
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        o[8*b +: 8] = n[8*b +: 8];
      end
    end
    return o;
  endfunction

  function automatic dcmx_mode_t mode_of(input logic [1:0] f);
    if (f == 2'h0) begin
      return mode_coarse;
    end else if (f == 2'h1) begin
      return mode_fs8;
    end
    return mode_nco;
  endfunction

  function automatic dcmx_csh_t csh_of(input logic [1:0] f);
    if (f == 2'h0) begin
      return csh_half;
    end else if (f == 2'h1) begin
      return csh_qplus;
    end
    return csh_qminus;
  endfunction

  // quarter-wave table, 16 steps per quadrant, q1.15
  function automatic logic [15:0] qtab(input logic [4:0] k);
    case (k)
      5'd0:    return 16'h0000;
      5'd1:    return 16'h0c8c;
      5'd2:    return 16'h18f9;
      5'd3:    return 16'h2528;
      5'd4:    return 16'h30fb;
      5'd5:    return 16'h3c56;
      5'd6:    return 16'h471c;
      5'd7:    return 16'h5133;
      5'd8:    return 16'h5a82;
      5'd9:    return 16'h62f1;
      5'd10:   return 16'h6a6d;
      5'd11:   return 16'h70e2;
      5'd12:   return 16'h7641;
      5'd13:   return 16'h7a7c;
      5'd14:   return 16'h7d89;
      5'd15:   return 16'h7f61;
      default: return 16'h7fff;
    endcase
  endfunction

  function automatic dcmx_samp_t sin_of(input logic [5:0] x);
    logic [15:0] m;
    m = x[4] ? qtab(5'd16 - {1'b0, x[3:0]}) : qtab({1'b0, x[3:0]});
    return x[5] ? -$signed(m) : $signed(m);
  endfunction

  function automatic logic clips(input logic signed [32:0] v);
    return v > 33'sh0_0000_7fff || v < -33'sh0_0000_8000;
  endfunction

  function automatic dcmx_samp_t sat16(input logic signed [32:0] v);
    if (v > 33'sh0_0000_7fff) begin
      return 16'h7fff;
    end else if (v < -33'sh0_0000_8000) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  // one rounding bit dropped per lane beyond the first
  function automatic dcmx_samp_t chsum(input dcmx_lanes_t v,
                                       input logic [3:0] en);
    logic signed [18:0] s;
    logic [2:0]         n;
    s = '0;
    n = '0;
    for (int k = 0; k < `DCMX_LANES; k++) begin
      if (en[k]) begin
        s = s + 19'($signed(v[k]));
        n = n + 3'd1;
      end
    end
    if (n > 3'd1) begin
      s = (s + (19'sd1 <<< (n - 3'd2))) >>> (n - 3'd1);
    end
    return s[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic       aw_hold;
  logic       w_hold;
  dcmx_addr_t aw_addr;
  dcmx_word_t w_data;
  dcmx_strb_t w_strb;
  logic       do_wr;
  logic [7:0] sum_cfg;
  logic [3:0] sat_live;
  dcmx_word_t rd_word;

  wire dcmx_word_t  rd_lane [`DCMX_LANES];
  wire dcmx_lanes_t mixp;
  wire logic [3:0]  satp;

  assign do_wr = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      aw_hold       <= 1'b0;
      aw_addr       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold       <= 1'b1;
      aw_addr       <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold <= 1'b0;
    end else if (!aw_hold && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_wready <= 1'b0;
      w_hold       <= 1'b0;
      w_data       <= '0;
      w_strb       <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold       <= 1'b1;
      w_data       <= s_axi_wdata;
      w_strb       <= s_axi_wstrb;
    end else if (do_wr) begin
      w_hold <= 1'b0;
    end else if (!w_hold && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DCMX_RESP_OK;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok(aw_addr) ? `DCMX_RESP_OK : `DCMX_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // routing of lanes into each channel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sum_cfg <= `DCMX_SUM_RST;
    end else if (do_wr && aw_addr == `DCMX_A_SUM) begin
      sum_cfg <= 8'(merge({24'h0, sum_cfg}, w_data, w_strb));
    end
  end

  always_comb begin
    rd_word = '0;
    if (is_lane(s_axi_araddr)) begin
      rd_word = rd_lane[s_axi_araddr[`DCMX_F_LANE]];
    end else if (s_axi_araddr == `DCMX_A_SUM) begin
      rd_word = {24'h0, sum_cfg};
    end else if (s_axi_araddr == `DCMX_A_STAT) begin
      rd_word = {28'h0, sat_live};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `DCMX_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= addr_ok(s_axi_araddr) ? `DCMX_RESP_OK
                                             : `DCMX_RESP_ERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // lanes

  for (genvar l = 0; l < `DCMX_LANES; l++) begin : g_lane
    logic [7:0]              ctrl;
    logic [`DCMX_FW-1:0]     freq;
    logic [`DCMX_FW-1:0]     acc;
    logic [15:0]             poff;
    dcmx_samp_t              dci;
    dcmx_samp_t              dcq;
    logic [2:0]              seq;
    dcmx_mode_t              mode;
    logic [15:0]             phase;
    logic [5:0]              idx;
    logic                    wr_me;
    dcmx_samp_t              in_i;
    dcmx_samp_t              in_q;
    dcmx_samp_t              c1;
    dcmx_samp_t              s1;
    dcmx_mode_t              m1;
    dcmx_csh_t               cs1;
    logic                    g1;
    logic [1:0]              seq1;
    logic signed [32:0]      prod;
    logic signed [32:0]      res;
    dcmx_samp_t              mix;
    logic                    sat;

    assign wr_me = do_wr && is_lane(aw_addr)
                   && aw_addr[`DCMX_F_LANE] == 2'(l);
    assign mode  = mode_of(ctrl[`DCMX_F_MODE]);

    // configuration written over the bus, held per lane
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ctrl <= `DCMX_CTRL_RST;
        freq <= '0;
        poff <= '0;
        dci  <= '0;
        dcq  <= '0;
      end else if (wr_me) begin
        if (aw_addr[`DCMX_F_REG] == `DCMX_R_CTRL) begin
          ctrl <= 8'(merge({24'h0, ctrl}, w_data, w_strb));
        end else if (aw_addr[`DCMX_F_REG] == `DCMX_R_FRQL) begin
          freq[31:0] <= merge(freq[31:0], w_data, w_strb);
        end else if (aw_addr[`DCMX_F_REG] == `DCMX_R_FRQH) begin
          {poff, freq[47:32]} <= merge({poff, freq[47:32]},
                                       w_data, w_strb);
        end else begin
          {dcq, dci} <= merge({dcq, dci}, w_data, w_strb);
        end
      end
    end

    assign rd_lane[l] =
      (s_axi_araddr[`DCMX_F_REG] == `DCMX_R_CTRL) ? {24'h0, ctrl} :
      (s_axi_araddr[`DCMX_F_REG] == `DCMX_R_FRQL) ? freq[31:0] :
      (s_axi_araddr[`DCMX_F_REG] == `DCMX_R_FRQH) ? {poff, freq[47:32]} :
      {dcq, dci};

    always_ff @(posedge clk) begin
      if (!rst_n) begin
        acc <= '0;
      end else if (mode == mode_nco) begin
        acc <= acc + freq;
      end
    end

    // coarse and eighth sequencer, one index per sample
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        seq <= '0;
      end else begin
        seq <= seq + 3'd1;
      end
    end

    // table resolution is 64 phases; finer phase only moves the step
    always_comb begin
      phase = acc[47:32] + poff;
      idx   = phase[15:10];
      if (mode == mode_fs8) begin
        idx = {3'(seq * {ctrl[`DCMX_F_F8], 1'b1}), 3'b000};
      end
    end

    // stage one: sample, coefficients and lane settings
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        in_i <= '0;
        in_q <= '0;
        c1   <= '0;
        s1   <= '0;
        m1   <= mode_coarse;
        cs1  <= csh_half;
        g1   <= 1'b0;
        seq1 <= '0;
      end else begin
        in_i <= ctrl[`DCMX_B_SRC] ? dci : $signed(link_i[l]);
        in_q <= ctrl[`DCMX_B_SRC] ? dcq : $signed(link_q[l]);
        c1   <= sin_of(idx + `DCMX_LUT_QTR);
        s1   <= sin_of(idx);
        m1   <= mode;
        cs1  <= csh_of(ctrl[`DCMX_F_CSH]);
        g1   <= ctrl[`DCMX_B_GAIN];
        seq1 <= seq[1:0];
      end
    end

    // stage two: mix; coarse bypasses the multipliers entirely
    always_comb begin
      prod = 33'(in_i) * 33'(c1) - 33'(in_q) * 33'(s1);
      res  = g1 ? (prod >>> `DCMX_SH_BOOST)
                : (prod >>> `DCMX_SH_LOW);
      if (m1 == mode_coarse) begin
        res = 33'(in_i);
        if (cs1 == csh_half) begin
          if (seq1[0]) begin
            res = -33'(in_i);
          end
        end else if (seq1 == 2'd1) begin
          res = (cs1 == csh_qplus) ? -33'(in_q) : 33'(in_q);
        end else if (seq1 == 2'd2) begin
          res = -33'(in_i);
        end else if (seq1 == 2'd3) begin
          res = (cs1 == csh_qplus) ? 33'(in_q) : -33'(in_q);
        end
      end
    end

    // clipping saturates rather than wrapping
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        mix <= '0;
        sat <= 1'b0;
      end else begin
        mix <= sat16(res);
        sat <= clips(res);
      end
    end

    assign mixp[l] = mix;
    assign satp[l] = sat;
  end

  ////////////////////////////////////////////////////////////////////
  // output summer

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chan_a   <= '0;
      chan_b   <= '0;
      sat_live <= '0;
    end else begin
      chan_a   <= chsum(mixp, sum_cfg[`DCMX_F_SUM_A]);
      chan_b   <= chsum(mixp, sum_cfg[`DCMX_F_SUM_B]);
      sat_live <= satp;
    end
  end

endmodule // dcmx_top

// ==== verif/dcmx_checker.sv ====
// dcmx_checker: port assertions for the mixer top
`timescale 1ns/1ps
module dcmx_checker (
  // clock, reset, channel outputs
  input wire logic                 clk,
  input wire logic                 rst_n,
  input wire dcmx_pkg::dcmx_samp_t chan_a,
  input wire dcmx_pkg::dcmx_samp_t chan_b,
  // register bus
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire dcmx_pkg::dcmx_word_t s_axi_rdata,
  input wire dcmx_pkg::dcmx_resp_t s_axi_rresp
);
  import dcmx_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////
  rst_out_a: assert property (
    $rose(rst_n) |-> chan_a == 0 && chan_b == 0)
    else $error("channel output not cleared by reset");
  wr_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid)
    else $error("write response late");
  b_done_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  w_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  aw_back_a: assert property (
    $fell(s_axi_bvalid) |-> ##[1:3] s_axi_awready && s_axi_wready)
    else $error("write channel not reopened");
  rd_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  r_done_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  r_block_a: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  err_zero_a: assert property (
    s_axi_rvalid && s_axi_rresp != 2'h0
    |-> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)
    else $error("error read carries data");
endmodule // dcmx_checker

// ==== verif/dcmx_link_src.sv ====
// dcmx_link_src: link-side source, one random i/q pair per lane
`timescale 1ns/1ps
module dcmx_link_src (
  // clock
  input  wire logic            clk,
  // samples towards the lanes
  output dcmx_pkg::dcmx_lanes_t link_i,
  output dcmx_pkg::dcmx_lanes_t link_q
);
  import dcmx_pkg::*;
////////////////////////////////////////////////////////////////////////
  initial begin
    link_i = 64'h0;
    link_q = 64'h0;
  end
  // fresh pair each clock: stale values would hide a stuck stage
  always @(posedge clk) begin
    link_i <= {$urandom, $urandom};
    link_q <= {$urandom, $urandom};
  end
endmodule // dcmx_link_src

// ==== verif/tb_dcmx_top.sv ====
// tb_dcmx_top: self-checking bench for the mixer top
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb_dcmx_top;
  import dcmx_pkg::*;
  logic        clk = 1'h0, rst_n = 1'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_bready = 1'h1;
  logic        s_axi_rready = 1'h1, f;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  dcmx_addr_t  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  dcmx_word_t  s_axi_wdata = 32'h0, s_axi_rdata, rd;
  dcmx_strb_t  s_axi_wstrb = 4'h0;
  dcmx_resp_t  s_axi_bresp, s_axi_rresp, rsp;
  dcmx_lanes_t link_i, link_q;
  dcmx_samp_t  chan_a, chan_b, x, qv, smp[12], ev[4], li[4], hx[$];
  int          miscompares = 0, compares = 0, p;

  dcmx_top dcmx_top_i (.*);
  dcmx_link_src dcmx_link_src_i (.clk(clk), .link_i(link_i), .link_q(link_q));
  always #2.5 clk = ~clk;
////////////////////////////////////////////////////////////////////////
  function automatic dcmx_samp_t ng(dcmx_samp_t v);
    return (v == 16'h8000) ? 16'h7fff : -v;
  endfunction
  function automatic dcmx_samp_t mx(int v, int b);
    return dcmx_samp_t'((v * 32'sh7fff) >>> (16 - b));
  endfunction
  function automatic dcmx_samp_t sm(logic [3:0] m);
    int s, n;
    s = 0;
    n = 0;
    for (int k = 0; k < 4; k++) begin
      if (m[k]) begin
        s += li[k];
        n++;
      end
    end
    if (n < 2) return dcmx_samp_t'(s);
    return dcmx_samp_t'((s + (1 << (n - 2))) >>> (n - 1));
  endfunction
  task automatic wr(input dcmx_addr_t a, input dcmx_word_t d,
                    input dcmx_strb_t s = 4'hf);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
  endtask
  task automatic rdr(input dcmx_addr_t a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask
  // lane k: freq low, freq high and offset, constant, control last
  task automatic cfg(input int k, input dcmx_word_t h, input dcmx_word_t d,
                     input dcmx_word_t c);
    wr(8'(k * 16 + 4), 32'h0);
    wr(8'(k * 16 + 8), h);
    wr(8'(k * 16 + 12), d);
    wr(8'(k * 16), c);
    repeat (6) @(posedge clk);
  endtask
  task automatic grab(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      smp[k] = chan_a;
    end
  endtask
  task automatic close_out;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////
  initial begin
    #60000;
    miscompares++;
    close_out;
  end
  initial begin
    void'($urandom(97298));
    repeat (5) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    rdr(8'h40);
    `CHK(rd, 32'hc3)
    rdr(8'h10);
    `CHK(rd, 32'h0)
    wr(8'h48, 32'h1);
    `CHK(rsp, 2'h2)
    rdr(8'h48);
    `CHK({rsp, rd}, {2'h2, 32'h0})
    wr(8'h44, 32'hf);
    `CHK(rsp, 2'h0)
    wr(8'h04, 32'hffffffff, 4'h5);
    rdr(8'h04);
    `CHK(rd, 32'h00ff00ff)
    // lane 0 alone on channel a, fed from the link
    wr(8'h40, 32'hc1);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 24; k++) begin
      @(posedge clk);
      hx.push_back(link_i[0]);
      if (k >= 3) begin
        x = hx[k - 3];
        if (k == 3) f = (chan_a !== x);
        `CHK(chan_a, f ? ng(x) : x)
        f = !f;
      end
    end
    // coarse shifts from the constant path, boost set on one
    for (int c = 0; c < 3; c++) begin
      x = 16'($urandom_range(16383, 1));
      qv = 16'($urandom_range(32000, 16384));
      if (c == 0) ev = '{x, ng(x), x, ng(x)};
      else if (c == 1) ev = '{x, ng(qv), ng(x), qv};
      else ev = '{x, qv, ng(x), ng(qv)};
      cfg(0, 32'h0, {qv, x}, 32'(32'h80 | (c << 2) | ((c == 1) << 6)));
      grab(8);
      p = 0;
      for (int j = 3; j >= 0; j--) if (smp[j] === x) p = j;
      for (int j = 0; j < 4; j++) `CHK(smp[p + j], ev[j])
    end
    // full oscillator held at zero and quarter phase
    for (int b = 0; b < 2; b++) begin
      for (int o = 0; o < 2; o++) begin
        x = b ? 16'h8000 : 16'($urandom);
        qv = 16'($urandom);
        cfg(0, {o ? 16'h4000 : 16'h0, 16'h0}, {qv, x}, 32'(32'h82 | (b << 6)));
        grab(1);
        `CHK(smp[0], o ? mx(-qv, b) : mx(x, b))
      end
    end
    // top frequency bit only: phase flips every sample
    cfg(0, 32'h8000, {16'h0, x}, 32'h82);
    grab(8);
    f = (smp[0] !== mx(x, 0));
    for (int j = 0; j < 8; j++) begin
      `CHK(smp[j], f ? mx(-x, 0) : mx(x, 0))
      f = !f;
    end
    // eighth-rate choices
    for (int m = 0; m < 4; m++) begin
      cfg(0, 32'h0, 32'h4000, 32'(32'h81 | (m << 4)));
      grab(12);
      p = 0;
      for (int j = 7; j >= 0; j--) if (smp[j] === mx(16384, 0)) p = j;
      `CHK(smp[p + 2], 16'h0)
      `CHK(smp[p + 4], mx(-16384, 0))
      `CHK(smp[p + 1] > 0, m == 0 || m == 3)
    end
    // second reset clears the accumulators before the summer test
    rst_n <= 1'h0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      x = 16'($urandom_range(16000, 0)) - 16'h1f40;
      li[k] = mx(x, 0);
      cfg(k, 32'h0, {16'h0, x}, 32'h82);
    end
    for (int m = 0; m < 16; m++) begin
      wr(8'h40, 32'(((15 - m) << 4) | m));
      repeat (6) @(posedge clk);
      @(posedge clk);
      `CHK(chan_a, sm(4'(m)))
      `CHK(chan_b, sm(4'(15 - m)))
    end
    // boost at 45 degrees with full-scale i and q saturates and flags
    // accumulators sit at zero since the second reset, so phase is known
    wr(8'h40, 32'h1);
    cfg(0, 32'h2000_0000, 32'h8000_7fff, 32'hc3);
    grab(1);
    `CHK(smp[0], 16'h7fff)
    rdr(8'h44);
    `CHK(rd[3:0], 4'h1)
    close_out;
  end
endmodule // tb_dcmx_top
bind dcmx_top dcmx_checker dcmx_checker_i (.*);
